// File: hdl/autobaud_defs.svh
// Contract
// R1: Measure in 8-bit async and LIN; LIN arms each packet; enable bit async only.
// R2: DALI ignores the enable bit; software writes the divisor for 1200 baud.
// R3: During measurement receive edges time the baud generator; pattern is 55h.
// R4: In 8-bit async, enable bit arms; first falling edge after it starts.
// R5: Receiver state machine held idle for the whole measurement.
// R6: First falling edge starts the counter upward from zero on measurement clock.
// R7: Fifth falling edge loads count into divisor, clears enable, sets done flag.
// R8: Software clears the done flag; hardware never clears it.
// R9: Receive-idle goes low at first falling edge, high at fifth rising edge.
// R10: Speed select 1 gives Fosc/4 and Fosc/32; 0 gives Fosc/16 and Fosc/128.
// R11: During measurement the generator is a 16-bit counter at base clock/8.
// R12: Visible divisor keeps old value until measurement completes.
// R13: With wake-on-break set, skip the break and measure the next byte.
// R14: Software checks the incoming rate is measurable with the chosen clock.
`ifndef AUTOBAUD_DEFS_SVH
`define AUTOBAUD_DEFS_SVH

`define ABD_OFS_CTRL    8'h00
`define ABD_OFS_STATUS  8'h04
`define ABD_OFS_DIVISOR 8'h08

`define CTRL_ENABLE   0
`define CTRL_WAKE     1
`define CTRL_SPEED    2
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 5

`define STAT_DONE 0
`define STAT_IDLE 1
`define STAT_MEAS 2

`define DIVISOR_RESET 16'h0000
`define COUNT_W       16
`define ABD_DIV_FAST  32
`define ABD_DIV_SLOW  128
`define SYNC_EDGES    3'h5

`endif

// File: hdl/autobaud_pkg.sv
package autobaud_pkg;
	typedef enum logic [1:0] {
		MODE_ASYNC8 = 2'h0,
		MODE_LIN    = 2'h1,
		MODE_DALI   = 2'h2,
		MODE_OTHER  = 2'h3
	} uart_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_ARMED    = 3'h1,
		ST_COUNT    = 3'h3,
		ST_BRK_WAIT = 3'h4,
		ST_BRK_LOW  = 3'h5
	} abd_state_t;
endpackage : autobaud_pkg

// File: hdl/abd_tick_if.sv
`timescale 1ns/1ps
interface abd_tick_if;
	logic run;
	logic fast;
	logic tick;
	modport src  (input run, input fast, output tick);
	modport user (output run, output fast, input tick);
endinterface : abd_tick_if

// File: hdl/abd_tick_div.sv
`timescale 1ns/1ps
`include "autobaud_defs.svh"
module abd_tick_div #(
	parameter int DIV_FAST = `ABD_DIV_FAST,
	parameter int DIV_SLOW = `ABD_DIV_SLOW
) (
	// System
	input wire logic clock,
	input wire logic arst_n,
	// Tick towards the measurement counter
	abd_tick_if.src  tk
);
	logic [7:0] cnt_ff;
	logic [7:0] lim;

	// R10: prescale select
	assign lim = tk.fast ? 8'(DIV_FAST - 1) : 8'(DIV_SLOW - 1);

	// Restart from zero with each run so the first period is whole
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 8'h00;
		end else if (!tk.run || cnt_ff == lim) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// R11: one tick per eight base clocks
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tk.tick <= 1'b0;
		end else begin
			tk.tick <= tk.run && cnt_ff == lim;
		end
	end

	a_tick_spacing: assert property (@(posedge clock) disable iff (!arst_n)
		tk.tick |=> !tk.tick [*8]) // R10
		else $error("measurement tick too frequent");
endmodule : abd_tick_div

// File: hdl/uart_autobaud_detect.sv
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "autobaud_defs.svh"
module uart_autobaud_detect #(
	parameter int COUNT_W = `COUNT_W
) (
	// System
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	// Receive line and LIN framing
	input  wire logic                    rx,
	input  wire logic                    lin_packet_start,
	// Towards the receiver
	output logic                         receiver_hold,
	output logic                         receive_idle_status,
	output logic                         autobaud_measurement,
	output logic      [COUNT_W-1:0]      baud_divisor,
	output autobaud_pkg::uart_mode_t     uart_mode,
	output logic                         baud_speed_select
);
	import autobaud_pkg::*;

	abd_state_t          state_ff;
	abd_state_t          nxt_state;
	uart_mode_t          mode_ff;
	logic                enable_ff;
	logic                wake_ff;
	logic                speed_ff;
	logic                done_ff;
	logic                idle_ff;
	logic                rx_q_ff;
	logic [2:0]          fall_cnt_ff;
	logic [2:0]          rise_cnt_ff;
	logic [COUNT_W-1:0]  count_ff;
	logic [COUNT_W-1:0]  divisor_ff;
	logic                wr_pend_ff;
	logic [7:0]          addr_ff;
	logic [31:0]         rdata_ff;
	logic                take;
	logic                wr_ctrl;
	logic                wr_stat;
	logic                wr_div;
	logic                fall;
	logic                rise;
	logic                sw_arm;
	logic                lin_arm;
	logic                abort;
	logic                start;
	logic                load;

	abd_tick_if tk ();

	abd_tick_div u_div (
		.clock  (clock),
		.arst_n (arst_n),
		.tk     (tk.src)
	);

	// R3: the receive edges gate the counter clock
	assign tk.run  = state_ff == ST_COUNT;
	assign tk.fast = speed_ff;

	// Bus slave: never stalls, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;
	assign take      = hsel && hready && htrans[1];

	function automatic logic [31:0] read_reg(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`ABD_OFS_CTRL: begin
				r[`CTRL_ENABLE] = enable_ff;
				r[`CTRL_WAKE]   = wake_ff;
				r[`CTRL_SPEED]  = speed_ff;
				r[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode_ff;
			end
			`ABD_OFS_STATUS: begin
				r[`STAT_DONE] = done_ff;
				r[`STAT_IDLE] = idle_ff;
				r[`STAT_MEAS] = state_ff != ST_IDLE;
			end
			`ABD_OFS_DIVISOR: begin
				r[COUNT_W-1:0] = divisor_ff;
			end
			default: begin
				r = 32'h0000_0000;
			end
		endcase
		return r;
	endfunction : read_reg

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
		end else begin
			wr_pend_ff <= take && hwrite;
			if (take) begin
				addr_ff <= haddr[7:0];
			end
		end
	end

	// Read data is sampled in the address phase; a write in the
	// immediately preceding data phase is not yet visible
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			rdata_ff <= read_reg(haddr[7:0]);
		end
	end

	assign wr_ctrl = wr_pend_ff && addr_ff == `ABD_OFS_CTRL;
	assign wr_stat = wr_pend_ff && addr_ff == `ABD_OFS_STATUS;
	assign wr_div  = wr_pend_ff && addr_ff == `ABD_OFS_DIVISOR;

	// Inputs are synchronous; one register gives the edges
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_q_ff <= 1'b1;
		end else begin
			rx_q_ff <= rx;
		end
	end

	assign fall = rx_q_ff && !rx;
	assign rise = !rx_q_ff && rx;

	// R1: enable bit only counts in 8-bit async
	assign sw_arm  = mode_ff == MODE_ASYNC8 && enable_ff;
	// R1: LIN measures every packet unasked
	assign lin_arm = mode_ff == MODE_LIN && lin_packet_start;
	// Outside LIN mode, a clear enable or any mode but 8-bit async abandons a sequence
	assign abort   = mode_ff == MODE_LIN ? 1'b0 : !sw_arm;
	assign start   = state_ff == ST_ARMED && fall;
	// R7: fifth falling edge ends the count
	assign load    = state_ff == ST_COUNT && fall && fall_cnt_ff == 3'(`SYNC_EDGES - 3'h1);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				// R4: async arms from the enable bit
				if (sw_arm) begin
					// R13: skip a break first
					nxt_state = wake_ff ? ST_BRK_WAIT : ST_ARMED;
				end else if (lin_arm) begin
					nxt_state = ST_ARMED;
				end
			end
			ST_BRK_WAIT: begin
				if (fall) begin
					nxt_state = ST_BRK_LOW;
				end
			end
			ST_BRK_LOW: begin
				if (rise) begin
					nxt_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (fall) begin
					nxt_state = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (load) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (state_ff != ST_IDLE && abort) begin
			nxt_state = ST_IDLE;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// R5: receiver held idle throughout
	assign receiver_hold        = state_ff != ST_IDLE;
	assign autobaud_measurement = state_ff != ST_IDLE;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fall_cnt_ff <= 3'h0;
		end else if (start) begin
			fall_cnt_ff <= 3'h1;
		end else if (state_ff == ST_COUNT && fall) begin
			fall_cnt_ff <= fall_cnt_ff + 3'h1;
		end
	end

	// R6: count from zero on the first falling edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= '0;
		end else if (start) begin
			count_ff <= '0;
		end else if (state_ff == ST_COUNT && tk.tick) begin
			// R11: internal 16-bit counter; overrange wraps
			count_ff <= count_ff + COUNT_W'(1);
		end
	end

	// R12: visible divisor changes only on completion or by software
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			divisor_ff <= `DIVISOR_RESET;
		end else if (load) begin
			// R7: average bit time into divisor
			divisor_ff <= count_ff;
		end else if (wr_div) begin
			// R2: manual divisor for DALI
			divisor_ff <= hwdata[COUNT_W-1:0];
		end
	end

	assign baud_divisor = divisor_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wake_ff  <= 1'b0;
			speed_ff <= 1'b0;
			mode_ff  <= MODE_ASYNC8;
		end else if (wr_ctrl) begin
			wake_ff  <= hwdata[`CTRL_WAKE];
			speed_ff <= hwdata[`CTRL_SPEED];
			mode_ff  <= uart_mode_t'(hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
		end
	end

	assign uart_mode         = mode_ff;
	assign baud_speed_select = speed_ff;

	// Software write to the enable takes precedence over the auto clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable_ff <= 1'b0;
		end else if (wr_ctrl) begin
			enable_ff <= hwdata[`CTRL_ENABLE];
		end else if (load) begin
			// R7: enable clears itself
			enable_ff <= 1'b0;
		end
	end

	// R8: only a software write of one clears; a new set wins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			done_ff <= 1'b0;
		end else if (load) begin
			done_ff <= 1'b1;
		end else if (wr_stat && hwdata[`STAT_DONE]) begin
			done_ff <= 1'b0;
		end
	end

	// R9: idle low from first fall to fifth rise
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			idle_ff     <= 1'b1;
			rise_cnt_ff <= 3'h0;
		end else if (start) begin
			idle_ff     <= 1'b0;
			rise_cnt_ff <= 3'h0;
		end else if (state_ff != ST_IDLE && abort) begin
			idle_ff     <= 1'b1;
		end else if (!idle_ff && rise) begin
			rise_cnt_ff <= rise_cnt_ff + 3'h1;
			if (rise_cnt_ff == 3'(`SYNC_EDGES - 3'h1)) begin
				idle_ff <= 1'b1;
			end
		end
	end

	assign receive_idle_status = idle_ff;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	a_load_copies_count: assert property ( // R7
		load |=> baud_divisor == $past(count_ff))
		else $error("divisor not loaded from count");
	a_load_flags: assert property ( // R7
		load && !wr_ctrl |=> !enable_ff && done_ff && state_ff == ST_IDLE)
		else $error("completion did not clear enable or set flag");
	a_divisor_holds: assert property ( // R12
		state_ff == ST_COUNT && !load && !wr_div |=> $stable(baud_divisor))
		else $error("divisor moved during measurement");
	a_start_zero: assert property ( // R6
		start |=> count_ff == '0 && state_ff == ST_COUNT ##1 tk.run)
		else $error("count did not start at zero");
	a_count_step: assert property ( // R11
		state_ff == ST_COUNT && tk.tick && !load
		|=> count_ff == $past(count_ff) + COUNT_W'(1))
		else $error("counter missed a tick");
	a_hold_idle_low: assert property ( // R5
		state_ff == ST_COUNT |-> receiver_hold && !receive_idle_status)
		else $error("receiver free or idle high while counting");
	a_idle_first_fall: assert property ( // R9
		start |=> !receive_idle_status)
		else $error("idle status did not drop at first edge");
	a_async_arm: assert property ( // R4
		state_ff == ST_IDLE && sw_arm && !wake_ff |=> state_ff == ST_ARMED)
		else $error("enable bit did not arm");
	a_wake_skip: assert property ( // R13
		state_ff == ST_IDLE && sw_arm && wake_ff |=> state_ff == ST_BRK_WAIT)
		else $error("break not skipped");
	a_dali_ignore: assert property ( // R2
		state_ff == ST_IDLE && mode_ff == MODE_DALI |=> state_ff == ST_IDLE)
		else $error("measurement started in DALI mode");
	a_lin_auto: assert property ( // R1
		state_ff == ST_IDLE && lin_arm |=> state_ff == ST_ARMED)
		else $error("LIN packet did not arm");

	c_done: cover property (load);
	c_done_wake: cover property (load && wake_ff);
	c_lin_done: cover property (load && mode_ff == MODE_LIN);
	c_abort: cover property (state_ff == ST_COUNT && abort);
endmodule : uart_autobaud_detect

// File: tb/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
	// System
	input  wire logic clock,
	// Serial line
	output logic      rx
);
	initial rx = 1'b1;

	task automatic send(input logic [7:0] data, input int bit_clks);
		logic [9:0] frame;
		frame = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx <= frame[i];
			repeat (bit_clks) @(posedge clock);
		end
	endtask : send

	task automatic send_break(input int bit_clks);
		rx <= 1'b0;
		repeat (13 * bit_clks) @(posedge clock);
		rx <= 1'b1;
		repeat (bit_clks) @(posedge clock);
	endtask : send_break
endmodule : serial_tx_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
	import autobaud_pkg::*;
	logic        clock;
	logic        arst_n;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rx;
	logic        lin_packet_start;
	logic        receiver_hold;
	logic        receive_idle_status;
	logic        autobaud_measurement;
	logic [15:0] baud_divisor;
	uart_mode_t  uart_mode;
	logic        baud_speed_select;
	logic        seen_meas;
	logic        watch_clr;
	int          failures;
	int          checks_done;
	logic [31:0] d;

	uart_autobaud_detect u_uart_autobaud_detect (.clock(clock), .arst_n(arst_n), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx(rx),
		.lin_packet_start(lin_packet_start), .receiver_hold(receiver_hold),
		.receive_idle_status(receive_idle_status), .autobaud_measurement(autobaud_measurement),
		.baud_divisor(baud_divisor), .uart_mode(uart_mode),
		.baud_speed_select(baud_speed_select));
	serial_tx_model u_serial_tx_model (.clock(clock), .rx(rx));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// One process owns the sticky flag; the test only requests a clear
	always @(posedge clock) begin
		if (watch_clr) begin
			seen_meas <= 1'b0;
		end else if (autobaud_measurement === 1'b1) begin
			seen_meas <= 1'b1;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		d = hrdata;
		@(posedge clock);
	endtask : bus

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, d, exp);
	endtask : rchk

	// Bit time chosen so 8 bit times fall mid-tick; rate kept measurable
	task automatic measure(input int k, input logic fast, input logic [15:0] old_div);
		int b;
		b = fast ? 4 * k + 2 : 16 * k + 8;
		fork
			u_serial_tx_model.send(8'h55, b);
			begin
				@(negedge rx);
				repeat (3) @(posedge clock);
				check("hold", receiver_hold, 1'b1);
				check("measuring", autobaud_measurement, 1'b1);
				check("idle low", receive_idle_status, 1'b0);
				check("old divisor", baud_divisor, old_div);
				rchk("status busy", 8'h04, 32'h4);
				repeat (4) @(posedge rx);
				check("idle before rise 5", receive_idle_status, 1'b0);
				@(posedge rx);
				repeat (2) @(posedge clock);
				check("idle after rise 5", receive_idle_status, 1'b1);
			end
		join
		repeat (2) @(posedge clock);
		check("divisor", baud_divisor, k[15:0]);
		check("idle high", receive_idle_status, 1'b1);
		check("hold off", receiver_hold, 1'b0);
		rchk("status done", 8'h04, 32'h3);
		repeat (50) @(posedge clock);
		rchk("done sticky", 8'h04, 32'h3);
		bus(1'b1, 8'h04, 32'h1);
		rchk("done cleared", 8'h04, 32'h2);
	endtask : measure

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// Eight frames of at most about 1700 cycles each plus bus traffic stay far below this
	initial begin
		repeat (30000) @(posedge clock);
		failures++;
		$display("CHECK FAILED watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		int k;
		logic f;
		arst_n = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		lin_packet_start = 1'b0;
		watch_clr = 1'b0;
		failures = 0;
		checks_done = 0;
		k = $urandom(93658);
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rchk("ctrl reset", 8'h00, 32'h0);
		rchk("status reset", 8'h04, 32'h2);
		rchk("divisor reset", 8'h08, 32'h0);
		rchk("unmapped", 8'h0C, 32'h0);
		check("resp okay", hresp, 1'b0);
		$display("test reset done");
		// Fast and slow clocks, async enable, each twice
		for (int i = 0; i < 4; i++) begin
			f = i[0];
			k = f ? $urandom_range(40, 2) : $urandom_range(10, 1);
			bus(1'b1, 8'h00, {29'h0, f, 2'h1});
			check("speed", baud_speed_select, f);
			measure(k, f, baud_divisor);
			rchk("enable cleared", 8'h00, {29'h0, f, 2'h0});
			$display("test async %0d done", i);
		end
		bus(1'b1, 8'h08, 32'h21);
		bus(1'b1, 8'h00, 32'h25);
		check("mode dali", uart_mode, MODE_DALI);
		watch_clr <= 1'b1;
		@(posedge clock);
		watch_clr <= 1'b0;
		u_serial_tx_model.send(8'h55, 30);
		check("dali no measure", seen_meas, 1'b0);
		check("dali divisor", baud_divisor, 16'h0021);
		$display("test dali done");
		bus(1'b1, 8'h00, 32'h14);
		check("mode lin", uart_mode, MODE_LIN);
		lin_packet_start <= 1'b1;
		@(posedge clock);
		lin_packet_start <= 1'b0;
		measure(7, 1'b1, 16'h0021);
		$display("test lin done");
		bus(1'b1, 8'h00, 32'h7);
		u_serial_tx_model.send_break(20);
		measure(5, 1'b1, 16'h0007);
		$display("test wake done");
		// Dropping the enable mid-count must leave the divisor untouched
		bus(1'b1, 8'h00, 32'h5);
		fork
			u_serial_tx_model.send(8'h55, 30);
			begin
				repeat (40) @(posedge clock);
				bus(1'b1, 8'h00, 32'h4);
			end
		join
		check("abort hold", receiver_hold, 1'b0);
		check("abort divisor", baud_divisor, 16'h0005);
		check("abort idle", receive_idle_status, 1'b1);
		rchk("abort status", 8'h04, 32'h2);
		$display("test abort done");
		stop_test();
	end
endmodule : tb
